// *** design/ptpi_pkg.sv ***
// Behaviour
// - any channel listens any slot, either bus
// - channel n maps to base plus n
// - transmit only in eight consecutive own slots
// - latch selected slot sample per channel
// - both buses handled by identical logic
// - receive source named by slot and bus
// - poll all eight channels for events
// - report changes since previous report when polled
// - commands in, status out, same bus
// - indicator register drives red, yellow, green
// - clock strap 2.048 or 1.544, default 1.544
// - law strap A or mu, default mu
// - diagnostic serial port, backplane or jack
// - separate per-bus registers, bus select chooses
// - wink bit high while off hook and loop current open
package ptpi_pkg;
   localparam int NCH = 8;
   localparam int SW = 8;
   localparam int AW = 8;
   localparam int STW = 24;
   // register byte offsets
   localparam logic [AW-1:0] A_CTRL = 8'h00;
   localparam logic [AW-1:0] A_STS = 8'h04;
   localparam logic [AW-1:0] A_MASK = 8'h08;
   localparam logic [AW-1:0] A_LED = 8'h0C;
   localparam logic [AW-1:0] A_STRAP = 8'h10;
   localparam logic [AW-1:0] A_LINE = 8'h14;
   localparam logic [AW-1:0] A_RPT = 8'h18;
   localparam logic [AW-1:0] A_DIAG = 8'h1C;
   localparam logic [AW-1:0] A_RXSEL = 8'h20;
   localparam logic [AW-1:0] A_DIG = 8'h40;
   localparam logic [AW-1:0] A_RXD = 8'h60;
   // field positions
   localparam int CT_TXBUS = 8;
   localparam int CT_TXEN = 9;
   localparam int CT_HOOK = 10;
   localparam int CT_JACK = 18;
   localparam int RS_BUS = 8;
   localparam int ST_DIG = 8;
   localparam int ST_WNK = 16;
   localparam int LN_WNK = 8;
   localparam int DG_BUSY = 8;
   localparam int DG_RXD = 9;
   localparam int SP_CLK = 0;
   localparam int SP_LAW = 1;
   localparam logic [2:0] LED_RST = 3'h7;
   // diagnostic serial timing
   localparam int CLK_HZ = 20000000;
   localparam int BAUD_HZ = 9600;
   localparam int BAUD_DIV = CLK_HZ / BAUD_HZ;
   localparam logic [3:0] UART_BITS = 4'hA;
   typedef enum logic [0:0] {PTPI_DG_IDLE = 1'b0, PTPI_DG_SEND = 1'b1} ptpi_dg_t;
   // offset of a slot inside an eight-slot block, or all ones
   function automatic logic [3:0] ptpi_blk(input logic [SW-1:0] slot, input logic [SW-1:0] base);
      logic [SW-1:0] d;
      d = slot - base;
      ptpi_blk = (d < SW'(NCH)) ? {1'b0, d[2:0]} : 4'hF;
   endfunction
endpackage

// *** design/ptpi_bus_port.sv ***
`timescale 1ns/1ns
// one backplane pcm bus: transmit block and per-channel capture
module ptpi_bus_port import ptpi_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slot_stb,
   input wire logic [SW-1:0] cur_slot,
   input wire logic bus_id,
   input wire logic tx_en,
   input wire logic tx_bus,
   input wire logic [SW-1:0] base_slot,
   input wire logic [NCH-1:0][SW-1:0] tx_samp,
   input wire logic [NCH-1:0][SW-1:0] rx_slot,
   input wire logic [NCH-1:0] rx_bus,
   input wire logic [SW-1:0] bus_in,
   output logic [SW-1:0] bus_out,
   output logic bus_oe_n,
   output logic [NCH-1:0][SW-1:0] cap_samp,
   output logic [NCH-1:0] cap_stb
);
   logic [SW-1:0] nxt_slot;
   logic [3:0] nxt_off;
   assign nxt_slot = cur_slot + SW'(1);
   assign nxt_off = ptpi_blk(nxt_slot, base_slot);

   // drive set up one slot ahead so the byte is stable for the whole slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_out <= 8'h00;
         bus_oe_n <= 1'b1;
      end else if (!tx_en || tx_bus != bus_id) begin
         bus_oe_n <= 1'b1;
      end else if (slot_stb) begin
         bus_oe_n <= nxt_off[3];
         bus_out <= nxt_off[3] ? 8'h00 : tx_samp[nxt_off[2:0]];
      end
   end

   // capture register per channel, independent of the other bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_samp <= '0;
         cap_stb <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            cap_stb[i] <= slot_stb && rx_slot[i] == cur_slot && rx_bus[i] == bus_id;
            if (slot_stb && rx_slot[i] == cur_slot && rx_bus[i] == bus_id)
               cap_samp[i] <= bus_in;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_cap_sample: assert property (slot_stb && rx_slot[0] == cur_slot && rx_bus[0] == bus_id
      |=> cap_stb[0] && cap_samp[0] == $past(bus_in)) else $error("capture missed");
   chk_drive_window: assert property ((slot_stb && tx_en && tx_bus == bus_id)
      |=> bus_oe_n == ($past(nxt_off) == 4'hF)) else $error("drive outside block");
   chk_release_off: assert property (!tx_en |=> bus_oe_n) else $error("bus not released");
   cov_drive: cover property (!bus_oe_n ##1 bus_oe_n);
endmodule // ptpi_bus_port

// *** design/ptpi_top.sv ***
`timescale 1ns/1ns
module ptpi_top import ptpi_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic frame_sync,
   input wire logic slot_stb,
   input wire logic [SW-1:0] pcm_a_in,
   output logic [SW-1:0] pcm_a_out,
   output logic pcm_a_oe_n,
   input wire logic [SW-1:0] pcm_b_in,
   output logic [SW-1:0] pcm_b_out,
   output logic pcm_b_oe_n,
   input wire logic [NCH-1:0][SW-1:0] codec_tx,
   output logic [NCH-1:0][SW-1:0] codec_rx,
   output logic [NCH-1:0] codec_rx_stb,
   input wire logic [NCH-1:0] ring_det,
   input wire logic [NCH-1:0] cur_open,
   input wire logic [NCH-1:0] digit_valid,
   input wire logic [NCH-1:0][3:0] digit_code,
   output logic [NCH-1:0] off_hook,
   input wire logic strap_clk_fast,
   input wire logic strap_alaw,
   output logic codec_clk_2m048,
   output logic codec_alaw,
   output logic led_red_n,
   output logic led_yellow_n,
   output logic led_green_n,
   input wire logic diag_rxd_bp,
   input wire logic diag_rxd_jack,
   output logic diag_txd_bp,
   output logic diag_txd_jack
);
   logic [31:0] ctrl_reg;
   logic [STW-1:0] sts_reg, sts_set, mask_reg;
   logic [2:0] led_reg;
   logic [NCH-1:0] chg_reg, chg_set;
   logic [NCH-1:0][SW-1:0] rxs_reg;
   logic [NCH-1:0] rxb_reg;
   logic [NCH-1:0][3:0] dig_reg;
   logic [NCH-1:0] ring_q, wink_q;
   logic [2:0] poll_idx;
   logic [SW-1:0] slot_cnt, cur_slot;
   logic strap_done;
   logic [NCH-1:0][SW-1:0] cap_a, cap_b;
   logic [NCH-1:0] stb_a, stb_b, wink_now;
   logic wr_go, rd_go, setup;
   logic [31:0] rd_val;
   logic rd_ok;
   ptpi_dg_t dg_state;
   logic [15:0] dg_div;
   logic [3:0] dg_cnt;
   logic [9:0] dg_sh;
   logic dg_txd;

   // true when an address falls inside the eight-word array starting at b
   function automatic logic in_arr(input logic [AW-1:0] a, input logic [AW-1:0] b);
      in_arr = a[AW-1:5] == b[AW-1:5];
   endfunction

   assign setup = psel && !penable;
   assign wr_go = psel && penable && pready && pwrite;
   assign rd_go = psel && penable && pready && !pwrite;
   assign wink_now = off_hook & cur_open;

   // frame sync forces slot 0; strobes step the slot counter
   assign cur_slot = frame_sync ? '0 : slot_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         slot_cnt <= '0;
      else if (slot_stb)
         slot_cnt <= cur_slot + SW'(1);
      else if (frame_sync)
         slot_cnt <= '0;
   end

   // both buses use the same engine
   ptpi_bus_port u_bus_a (
      .pclk(pclk), .presetn(presetn), .slot_stb(slot_stb), .cur_slot(cur_slot),
      .bus_id(1'b0), .tx_en(ctrl_reg[CT_TXEN]), .tx_bus(ctrl_reg[CT_TXBUS]),
      .base_slot(ctrl_reg[SW-1:0]), .tx_samp(codec_tx), .rx_slot(rxs_reg), .rx_bus(rxb_reg),
      .bus_in(pcm_a_in), .bus_out(pcm_a_out), .bus_oe_n(pcm_a_oe_n),
      .cap_samp(cap_a), .cap_stb(stb_a)
   );
   ptpi_bus_port u_bus_b (
      .pclk(pclk), .presetn(presetn), .slot_stb(slot_stb), .cur_slot(cur_slot),
      .bus_id(1'b1), .tx_en(ctrl_reg[CT_TXEN]), .tx_bus(ctrl_reg[CT_TXBUS]),
      .base_slot(ctrl_reg[SW-1:0]), .tx_samp(codec_tx), .rx_slot(rxs_reg), .rx_bus(rxb_reg),
      .bus_in(pcm_b_in), .bus_out(pcm_b_out), .bus_oe_n(pcm_b_oe_n),
      .cap_samp(cap_b), .cap_stb(stb_b)
   );

   // bus select picks which per-bus register feeds the codec
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         codec_rx <= '0;
         codec_rx_stb <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            codec_rx[i] <= rxb_reg[i] ? cap_b[i] : cap_a[i];
            codec_rx_stb[i] <= stb_a[i] | stb_b[i];
         end
      end
   end

   // round-robin poll, one channel per clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_idx <= '0;
         ring_q <= '0;
         wink_q <= '0;
         dig_reg <= '0;
      end else begin
         poll_idx <= poll_idx + 3'h1;
         ring_q[poll_idx] <= ring_det[poll_idx];
         wink_q[poll_idx] <= wink_now[poll_idx];
         if (digit_valid[poll_idx])
            dig_reg[poll_idx] <= digit_code[poll_idx];
      end
   end

   // events of the channel under poll
   always_comb begin
      sts_set = '0;
      chg_set = '0;
      sts_set[poll_idx] = ring_det[poll_idx] && !ring_q[poll_idx];
      sts_set[ST_DIG + poll_idx] = digit_valid[poll_idx];
      sts_set[ST_WNK + poll_idx] = wink_now[poll_idx] != wink_q[poll_idx];
      chg_set[poll_idx] = sts_set[poll_idx] | sts_set[ST_DIG + poll_idx] | sts_set[ST_WNK + poll_idx];
   end

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sts_reg <= '0;
      else if (wr_go && paddr == A_STS)
         sts_reg <= (sts_reg & ~pwdata[STW-1:0]) | sts_set;
      else
         sts_reg <= sts_reg | sts_set;
   end

   // change report cleared by the poll read, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         chg_reg <= '0;
      else if (rd_go && paddr == A_RPT)
         chg_reg <= chg_set;
      else
         chg_reg <= chg_reg | chg_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(sts_reg & mask_reg);
   end

   // software-written control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
         mask_reg <= '0;
         led_reg <= LED_RST;
         rxs_reg <= '0;
         rxb_reg <= '0;
      end else if (wr_go) begin
         if (paddr == A_CTRL)
            ctrl_reg <= pwdata;
         if (paddr == A_MASK)
            mask_reg <= pwdata[STW-1:0];
         if (paddr == A_LED)
            led_reg <= pwdata[2:0];
         if (in_arr(paddr, A_RXSEL) && paddr[1:0] == 2'b00) begin // misaligned words refused
            rxs_reg[paddr[4:2]] <= pwdata[SW-1:0];
            rxb_reg[paddr[4:2]] <= pwdata[RS_BUS];
         end
      end
   end

   // outputs that follow control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_hook <= '0;
         led_red_n <= LED_RST[0];
         led_yellow_n <= LED_RST[1];
         led_green_n <= LED_RST[2];
         diag_txd_bp <= 1'b1;
         diag_txd_jack <= 1'b1;
      end else begin
         off_hook <= ctrl_reg[CT_HOOK +: NCH];
         led_red_n <= led_reg[0];
         led_yellow_n <= led_reg[1];
         led_green_n <= led_reg[2];
         diag_txd_bp <= ctrl_reg[CT_JACK] | dg_txd;
         diag_txd_jack <= !ctrl_reg[CT_JACK] | dg_txd;
      end
   end

   // straps caught once after reset release; defaults are 1.544 and mu-law
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done <= 1'b0;
         codec_clk_2m048 <= 1'b0;
         codec_alaw <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         codec_clk_2m048 <= strap_clk_fast;
         codec_alaw <= strap_alaw;
      end
   end

   // diagnostic transmitter, 8n1; writes while busy are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dg_state <= PTPI_DG_IDLE;
         dg_div <= '0;
         dg_cnt <= '0;
         dg_sh <= '1;
      end else begin
         unique case (dg_state)
            PTPI_DG_IDLE: begin
               if (wr_go && paddr == A_DIAG) begin
                  dg_sh <= {1'b1, pwdata[7:0], 1'b0};
                  dg_div <= '0;
                  dg_cnt <= '0;
                  dg_state <= PTPI_DG_SEND;
               end
            end
            PTPI_DG_SEND: begin
               if (dg_div == 16'(BAUD_DIV - 1)) begin
                  dg_div <= '0;
                  dg_sh <= {1'b1, dg_sh[9:1]};
                  dg_cnt <= dg_cnt + 4'h1;
                  if (dg_cnt == UART_BITS - 4'h1)
                     dg_state <= PTPI_DG_IDLE;
               end else begin
                  dg_div <= dg_div + 16'h0001;
               end
            end
         endcase
      end
   end
   assign dg_txd = dg_sh[0];

   // read mux
   always_comb begin
      rd_val = '0;
      rd_ok = 1'b1;
      if (paddr[1:0] != 2'b00)
         rd_ok = 1'b0;
      else if (paddr == A_CTRL)
         rd_val = ctrl_reg;
      else if (paddr == A_STS)
         rd_val[STW-1:0] = sts_reg;
      else if (paddr == A_MASK)
         rd_val[STW-1:0] = mask_reg;
      else if (paddr == A_LED)
         rd_val[2:0] = led_reg;
      else if (paddr == A_STRAP) begin
         rd_val[SP_CLK] = codec_clk_2m048;
         rd_val[SP_LAW] = codec_alaw;
      end else if (paddr == A_LINE) begin
         rd_val[NCH-1:0] = ring_q;
         rd_val[LN_WNK +: NCH] = wink_q;
      end else if (paddr == A_RPT)
         rd_val[NCH-1:0] = chg_reg | chg_set;
      else if (paddr == A_DIAG) begin
         rd_val[DG_BUSY] = dg_state == PTPI_DG_SEND;
         rd_val[DG_RXD] = ctrl_reg[CT_JACK] ? diag_rxd_jack : diag_rxd_bp;
      end else if (in_arr(paddr, A_RXSEL))
         rd_val[RS_BUS:0] = {rxb_reg[paddr[4:2]], rxs_reg[paddr[4:2]]};
      else if (in_arr(paddr, A_DIG))
         rd_val[3:0] = dig_reg[paddr[4:2]];
      else if (in_arr(paddr, A_RXD))
         rd_val[SW-1:0] = codec_rx[paddr[4:2]];
      else
         rd_ok = 1'b0;
   end

   // one wait-free access phase; answer loaded during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !rd_ok;
         prdata <= (setup && !pwrite) ? rd_val : 32'h00000000;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_poll_step: assert property ($past(presetn) |-> poll_idx == $past(poll_idx) + 3'h1)
      else $error("poll did not advance");
   chk_rpt_clear: assert property (rd_go && paddr == A_RPT && chg_set == '0 |=> chg_reg == '0)
      else $error("report not cleared");
   chk_led_follow: assert property (wr_go && paddr == A_LED |=> ##1 led_red_n == $past(pwdata[0], 2))
      else $error("red indicator wrong");
   chk_strap_clk: assert property ($rose(strap_done) |-> codec_clk_2m048 == $past(strap_clk_fast))
      else $error("clock strap not taken");
   chk_strap_law: assert property (strap_done |=> $stable(codec_alaw))
      else $error("law changed after capture");
   chk_rx_mux: assert property (stb_b[0] && rxb_reg[0] |=> codec_rx[0] == $past(cap_b[0]))
      else $error("bus select mux wrong");
   chk_wink_poll: assert property (poll_idx == 3'h0 |=> wink_q[0] == $past(off_hook[0] & cur_open[0]))
      else $error("wink bit wrong");
   chk_sts_setwin: assert property (sts_set[0] |=> sts_reg[0])
      else $error("event lost");
   chk_unmapped_err: assert property (setup && paddr == 8'hFC |=> pready && pslverr)
      else $error("unmapped not refused");
   cov_irq: cover property ($rose(irq));
   cov_rx: cover property (codec_rx_stb[0]);
   cov_diag: cover property (dg_state == PTPI_DG_SEND ##1 dg_state == PTPI_DG_IDLE);
endmodule // ptpi_top

// *** tb/ptpi_bus_ctl_model.sv ***
`timescale 1ns/1ns
// backplane side: slot timing and other cards' samples
module ptpi_bus_ctl_model (
   input wire logic pclk,
   input wire logic presetn,
   output logic frame_sync,
   output logic slot_stb,
   output logic [7:0] slot_no,
   output logic [7:0] bus_a,
   output logic [7:0] bus_b
);
   logic [1:0] div_reg;
   // one strobe per four clocks leaves room for the capture pipeline
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 2'h0;
         slot_no <= 8'h00;
         slot_stb <= 1'b0;
         frame_sync <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         slot_stb <= (div_reg == 2'h3); // one byte per slot
         frame_sync <= (div_reg == 2'h3) && (slot_no == 8'h00);
         if (slot_stb) begin
            slot_no <= slot_no + 8'h01; // slot numbers name the sources
         end
      end
   end
   // samples differ per slot and bus, so a wrong pick shows
   assign bus_a = slot_no ^ 8'h5A;
   assign bus_b = slot_no ^ 8'hA5;
endmodule // ptpi_bus_ctl_model

// *** tb/pcm_timeslot_port_interface_tb.sv ***
`timescale 1ns/1ns
module pcm_timeslot_port_interface_tb import ptpi_pkg::*;;
   typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic er;} ptpi_row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, frame_sync, slot_stb;
   logic [7:0] paddr = 8'h00, slot_no, mdl_a, mdl_b, pcm_a_in, pcm_b_in, pcm_a_out, pcm_b_out;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pcm_a_oe_n, pcm_b_oe_n, clk2, alaw, led_r, led_y, led_g, txd_bp, txd_jack, e;
   logic strap_fast = 0, strap_a = 0, rxd_bp = 1, rxd_jack = 1;
   logic [NCH-1:0][SW-1:0] codec_tx, codec_rx;
   logic [NCH-1:0] rx_stb, off_hook, ring = '0, copen = '0, dvalid = '0;
   logic [NCH-1:0][3:0] dcode = '0;
   int num_errors = 0, comparisons = 0, hits;
   ptpi_row_t rows [8];
   always #25 pclk = ~pclk;
   // the backplane level is whoever drives; the card wins in its own slots
   assign pcm_a_in = pcm_a_oe_n ? mdl_a : pcm_a_out;
   assign pcm_b_in = pcm_b_oe_n ? mdl_b : pcm_b_out;
   initial for (int n = 0; n < NCH; n++) codec_tx[n] = 8'h10 + 8'(n);
   ptpi_bus_ctl_model mdl (.pclk(pclk), .presetn(presetn), .frame_sync(frame_sync), .slot_stb(slot_stb),
      .slot_no(slot_no), .bus_a(mdl_a), .bus_b(mdl_b));
   ptpi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .frame_sync(frame_sync), .slot_stb(slot_stb), .pcm_a_in(pcm_a_in), .pcm_a_out(pcm_a_out),
      .pcm_a_oe_n(pcm_a_oe_n), .pcm_b_in(pcm_b_in), .pcm_b_out(pcm_b_out), .pcm_b_oe_n(pcm_b_oe_n),
      .codec_tx(codec_tx), .codec_rx(codec_rx), .codec_rx_stb(rx_stb), .ring_det(ring), .cur_open(copen),
      .digit_valid(dvalid), .digit_code(dcode), .off_hook(off_hook), .strap_clk_fast(strap_fast),
      .strap_alaw(strap_a), .codec_clk_2m048(clk2), .codec_alaw(alaw), .led_red_n(led_r),
      .led_yellow_n(led_y), .led_green_n(led_g), .diag_rxd_bp(rxd_bp), .diag_rxd_jack(rxd_jack),
      .diag_txd_bp(txd_bp), .diag_txd_jack(txd_jack));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // setup edge, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("read data", rdv, exp);
   endtask
   task automatic do_reset(input logic f, input logic al);
      presetn <= 1'b0;
      strap_fast <= f;
      strap_a <= al;
      cyc(8);
      presetn <= 1'b1;
      cyc(2);
      chk("idle pins", {pcm_a_oe_n, pcm_b_oe_n, led_r, led_y, led_g, txd_bp, txd_jack}, 32'h7F);
      chk("straps", {clk2, alaw}, {f, al});
   endtask
   // one whole frame: the card drives only its eight slots, on one bus
   task automatic tx_frame(input logic [7:0] base, input logic bus);
      logic [7:0] k;
      apb(1'b1, A_CTRL, {22'h0, 1'b1, bus, base});
      do @(posedge pclk); while (!(slot_stb && frame_sync));
      repeat (256) begin
         do @(posedge pclk); while (slot_stb !== 1'b1);
         k = slot_no - base;
         chk("oe", {pcm_a_oe_n, pcm_b_oe_n}, {bus || k > 7, !bus || k > 7});
         if (k < 8) chk("tx", bus ? pcm_b_out : pcm_a_out, codec_tx[k[2:0]]);
      end
   endtask
   initial begin
      #(30000 * 50);
      num_errors++;
      final_report();
   end
   initial begin
      rows = '{'{A_CTRL, 32'h4, 32'h4, 0}, '{A_LED, 32'h5, 32'h5, 0}, '{A_MASK, 32'hFFFFFF, 32'hFFFFFF, 0},
         '{A_RXSEL, 32'h107, 32'h107, 0}, '{A_RXSEL + 8'h1C, 32'hC8, 32'hC8, 0}, '{A_STRAP, 32'h3, 32'h0, 0},
         '{8'hFC, 32'h1, 32'h0, 1}, '{8'h22, 32'h1, 32'h0, 1}};
      do_reset(0, 0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].wd);
         chk("wr err", e, rows[i].er);
         rd(rows[i].a, rows[i].rd);
         chk("rd err", e, rows[i].er);
      end
      chk("leds", {led_g, led_y, led_r}, 32'h5);
      // the misaligned row must not have touched channel 0's selection
      rd(A_RXSEL, 32'h107);
      // every channel listens to its own slot and bus
      apb(1'b1, A_CTRL, 32'h0);
      for (int n = 0; n < NCH; n++) apb(1'b1, A_RXSEL + 8'(4 * n), {23'h0, n[0], 8'(16 * n + 3)});
      cyc(2100);
      for (int n = 0; n < NCH; n++) begin
         chk("rx", codec_rx[n], 8'(16 * n + 3) ^ (n[0] ? 8'hA5 : 8'h5A));
         rd(A_RXD + 8'(4 * n), 8'(16 * n + 3) ^ (n[0] ? 8'hA5 : 8'h5A));
      end
      // one capture pulse per frame for the listening channel
      hits = 0;
      repeat (1024) begin
         @(posedge pclk);
         hits += rx_stb[0];
      end
      chk("rx stb", hits, 32'h1);
      apb(1'b1, A_RXSEL, 32'h5);
      tx_frame(8'h04, 1'b0);
      cyc(1100);
      chk("loopback", codec_rx[0], codec_tx[1]);
      tx_frame(8'hF0, 1'b1);
      // ring event: sticky status, report once, interrupt
      ring[2] <= 1'b1;
      cyc(20);
      rd(A_STS, 32'h4);
      chk("irq", irq, 1'b1);
      rd(A_RPT, 32'h4);
      rd(A_RPT, 32'h0);
      ring[2] <= 1'b0;
      apb(1'b1, A_STS, 32'h4);
      cyc(3);
      chk("irq clr", irq, 1'b0);
      apb(1'b1, A_MASK, 32'h0);
      ring[1] <= 1'b1;
      cyc(20);
      chk("irq mask", irq, 1'b0);
      rd(A_STS, 32'h2);
      ring[1] <= 1'b0;
      apb(1'b1, A_STS, 32'hFFFFFFFF);
      // wink shows only on the off-hook channel
      apb(1'b1, A_CTRL, 32'h2000);
      copen <= 8'h18;
      cyc(20);
      chk("hook", off_hook, 8'h08);
      rd(A_LINE, 32'h800);
      dcode[5] <= 4'h9;
      dvalid[5] <= 1'b1;
      cyc(20);
      dvalid[5] <= 1'b0;
      rd(A_DIG + 8'h14, 32'h9);
      rd(A_STS, 32'h82000);
      // serial port: start bit on the selected pin only
      rxd_bp <= 1'b0;
      apb(1'b1, A_DIAG, 32'h55);
      cyc(3);
      chk("txd", {txd_bp, txd_jack}, 32'h1);
      apb(1'b0, A_DIAG, 32'h0);
      chk("diag", rdv & 32'h300, 32'h100);
      // jack selected: start bit moves to the jack, receive pin follows
      rxd_jack <= 1'b0;
      rxd_bp <= 1'b1;
      apb(1'b1, A_CTRL, 32'h40000);
      cyc(2);
      chk("txd jack", {txd_bp, txd_jack}, 32'h2);
      apb(1'b0, A_DIAG, 32'h0);
      chk("diag jack", rdv & 32'h300, 32'h100);
      do_reset(1, 1);
      rd(A_STRAP, 32'h3);
      final_report();
   end
endmodule // pcm_timeslot_port_interface_tb
